// ===== shared/nipm_pkg.sv
/*
 * constants for the network indicator pin mux: configuration codes,
 * operation settings, apb register offsets and fields, reset values, timing.
 * assumes a single 10 MHz system clock and a 32-bit apb register bus.
 */
// How it works
// - shared indicator pins chosen by select input
// - shared pin indicators only in internal phy mode; link indicator in every mode
// - link indicator shows 10/100 link up
// - transmit indicator low while transmitting
// - receive indicator low while receiving
// - collision shown only at half duplex
// - duplex low full, from negotiation/setting
// - speed low at 100, high at 10
// - pll multiplies 25 MHz reference to 150
// - crystal reference in modes 0000 and 0001
// - oscillator reference only in mode 0010
// - external mode: pins carry transmit enable/nibble
package nipm_pkg;

    // ****************************************************************
    // configuration select codes
    // ****************************************************************
    localparam logic [3:0] CFG_INTERNAL_PHY = 4'h0; // indicators on shared pins
    localparam logic [3:0] CFG_EXT_CRYSTAL = 4'h1;  // external phy, crystal reference
    localparam logic [3:0] CFG_EXT_OSC = 4'h2;      // external phy, oscillator reference

    // ****************************************************************
    // phy operation setting codes (3 bits)
    // ****************************************************************
    localparam logic [2:0] OPSET_AUTO = 3'h0;      // follow autonegotiation
    localparam logic [2:0] OPSET_10_HALF = 3'h1;
    localparam logic [2:0] OPSET_10_FULL = 3'h2;
    localparam logic [2:0] OPSET_100_HALF = 3'h3;
    localparam logic [2:0] OPSET_100_FULL = 3'h4;

    // ****************************************************************
    // apb register map (byte addresses)
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CONTROL = 12'h000; // phy operation setting
    localparam logic [11:0] OFS_STATUS = 12'h004;  // read-only link and clock state
    localparam logic [11:0] OFS_CLOCK = 12'h008;   // read-only clock figures

    // control fields
    localparam int CTL_OPSET_LSB = 0;
    localparam logic [2:0] CTL_OPSET_RESET = 3'h0;

    // status fields
    localparam int STA_LINK = 0;
    localparam int STA_FULL_DUPLEX = 1;
    localparam int STA_SPEED100 = 2;
    localparam int STA_PLL_LOCKED = 3;
    localparam int STA_CRYSTAL_SEL = 4;
    localparam int STA_OSC_SEL = 5;
    localparam int STA_INDICATOR_MODE = 6;
    localparam int STA_EXT_MODE = 7;
    localparam int STA_CFG_LSB = 8;

    // clock fields
    localparam int CLK_REF_LSB = 0;
    localparam int CLK_CORE_LSB = 8;
    localparam int CLK_MULT_LSB = 16;

    // ****************************************************************
    // clock figures and timing
    // ****************************************************************
    localparam logic [7:0] REF_CLOCK_MHZ = 8'h19;  // 25 MHz reference
    localparam logic [7:0] CORE_CLOCK_MHZ = 8'h96; // 150 MHz core clock
    localparam logic [7:0] PLL_MULTIPLIER = 8'h06; // core over reference
    localparam int SYS_CLOCK_KHZ = 10000;          // CLK_IN rate
    localparam int PLL_LOCK_TIME_US = 100;         // least settle time after source change
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_US * SYS_CLOCK_KHZ + 999) / 1000;
    localparam int LOCK_CNT_W = 11;

endpackage

// ===== rtl/nipm_refclk_sel.sv
/*
 * reference clock source selection and pll lock tracking.
 * assumes the configuration select is stable during operation; a change that moves
 * the source restarts the lock wait because the pll loses its reference.
 */
`timescale 1ns/1ps
module nipm_refclk_sel (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // configuration
    input wire logic [3:0] cfg_select,
    // source and pll state
    output logic crystal_sel,
    output logic osc_sel,
    output logic pll_locked
);

    // ****************************************************************
    // source choice
    // ****************************************************************
    logic next_crystal_sel; // crystal pair feeds the pll
    logic next_osc_sel;     // dedicated oscillator feeds the pll
    logic [nipm_pkg::LOCK_CNT_W-1:0] lock_cnt; // cycles since source settled

    // decode the reference source from the configuration code
    always_comb begin
        // crystal in internal or crystal-external mode
        next_crystal_sel = (cfg_select == nipm_pkg::CFG_INTERNAL_PHY) ||
                           (cfg_select == nipm_pkg::CFG_EXT_CRYSTAL);
        next_osc_sel = (cfg_select == nipm_pkg::CFG_EXT_OSC);
    end

    // registered source selects
    always_ff @(posedge clk) begin
        if (!resetn) begin
            crystal_sel <= 1'b0;
            osc_sel <= 1'b0;
        end else begin
            crystal_sel <= next_crystal_sel;
            osc_sel <= next_osc_sel;
        end
    end

    // ****************************************************************
    // pll lock wait
    // ****************************************************************
    // pll settles before core clock counts as valid
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lock_cnt <= '0;
            pll_locked <= 1'b0;
        end else if ((next_crystal_sel != crystal_sel) || (next_osc_sel != osc_sel) ||
                     !(next_crystal_sel || next_osc_sel)) begin
            // source moved or no source: start over
            lock_cnt <= '0;
            pll_locked <= 1'b0;
        end else if (lock_cnt == nipm_pkg::LOCK_CNT_W'(nipm_pkg::PLL_LOCK_CYCLES - 1)) begin
            pll_locked <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + 1'b1;
        end
    end

endmodule

// ===== rtl/nipm_top.sv
/*
 * network indicator output logic with shared transmit interface pins.
 * assumes all inputs are synchronous to CLK_IN, the internal phy reports
 * link, activity and negotiation state as levels, and the external phy
 * transmit clock is slow enough to be sampled at CLK_IN.
 */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module nipm_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // configuration pins
    input wire logic [3:0] CFG_SELECT_IN,
    // internal phy state
    input wire logic LINK_UP_IN,
    input wire logic TX_ACTIVE_IN,
    input wire logic RX_ACTIVE_IN,
    input wire logic COLLISION_IN,
    input wire logic ANEG_FULL_DUPLEX_IN,
    input wire logic ANEG_SPEED100_IN,
    // external phy transmit side
    input wire logic MII_TXC_IN,
    input wire logic MII_TX_EN_IN,
    input wire logic [3:0] MII_TXD_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // indicator and shared pins
    output logic LINK_INDICATOR_OUT,
    output logic TX_ACTIVITY_INDICATOR_N_OUT,
    output logic RX_ACTIVITY_INDICATOR_N_OUT,
    output logic COLLISION_INDICATOR_N_OUT,
    output logic DUPLEX_INDICATOR_N_OUT,
    output logic SPEED_INDICATOR_N_OUT,
    // clock source state
    output logic CRYSTAL_SELECT_OUT,
    output logic OSC_SELECT_OUT,
    output logic PLL_LOCKED_OUT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [2:0] phy_operation_setting; // software duplex/speed choice
    logic full_duplex;        // resolved duplex
    logic speed100;           // resolved speed
    logic indicator_mode;     // shared pins carry indicators
    logic ext_mode;           // shared pins carry transmit interface

    // transmit capture
    logic txc_q;              // previous sample of transmit clock
    logic txc_rise;           // transmit clock rising edge seen
    logic tx_en_q;            // transmit enable launched on txc
    logic [3:0] txd_q;        // transmit nibble launched on txc

    // register bus
    logic apb_setup;          // setup phase of a transfer
    logic apb_done;           // completing access phase
    logic addr_hit;           // address maps to a register
    logic [31:0] next_prdata; // read data for the current address

    // mode scratch
    logic [1:0] resolved;     // duplex and speed from the setting

    // ****************************************************************
    // functions
    // ****************************************************************
    // resolve {full_duplex, speed100} from setting and negotiation
    function automatic logic [1:0] resolve_mode(input logic [2:0] setting,
                                                input logic aneg_fdx,
                                                input logic aneg_100);
        logic [1:0] res;

        // negotiated pair first
        res = {aneg_fdx, aneg_100};

        // manual choice overrides
        unique case (setting)
            nipm_pkg::OPSET_10_HALF: res = 2'h0;
            nipm_pkg::OPSET_10_FULL: res = 2'h2;

            nipm_pkg::OPSET_100_HALF: res = 2'h1;
            nipm_pkg::OPSET_100_FULL: res = 2'h3;

            // auto and spare codes
            default: res = {aneg_fdx, aneg_100};
        endcase

        return res;
    endfunction

    // true when the byte address names a mapped register
    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == nipm_pkg::OFS_CONTROL) || (addr == nipm_pkg::OFS_STATUS) ||
               (addr == nipm_pkg::OFS_CLOCK);
    endfunction

    // ****************************************************************
    // clock source and pll
    // ****************************************************************
    // source selects and lock come from the helper's own flops
    // lock restarts on a source move
    nipm_refclk_sel u_refclk_sel (
        .clk(CLK_IN),
        .resetn(RESETN_IN),
        .cfg_select(CFG_SELECT_IN),
        .crystal_sel(CRYSTAL_SELECT_OUT),
        .osc_sel(OSC_SELECT_OUT),
        .pll_locked(PLL_LOCKED_OUT)
    );

    // ****************************************************************
    // mode decode
    // ****************************************************************
    // pin function follows the configuration select
    always_comb begin
        // select input picks shared pin function
        // indicators only for internal phy code
        indicator_mode = (CFG_SELECT_IN == nipm_pkg::CFG_INTERNAL_PHY);

        ext_mode = (CFG_SELECT_IN == nipm_pkg::CFG_EXT_CRYSTAL) ||
                   (CFG_SELECT_IN == nipm_pkg::CFG_EXT_OSC);
        // spare codes leave both low

        // duplex and speed
        resolved = resolve_mode(phy_operation_setting, ANEG_FULL_DUPLEX_IN, ANEG_SPEED100_IN);
        full_duplex = resolved[1];
        speed100 = resolved[0];
    end

    // ****************************************************************
    // external transmit interface launch
    // ****************************************************************
    // edge seen when the sampled clock goes from low to high
    // txc above CLK_IN/2 loses edges
    assign txc_rise = MII_TXC_IN && !txc_q;

    // keep last sample of transmit clock
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            // pin idles low: no false edge
            txc_q <= 1'b0;
        end else begin
            txc_q <= MII_TXC_IN;
        end
    end

    // launch enable and nibble only on transmit clock edges
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            // nothing launched yet
            tx_en_q <= 1'b0;
            txd_q <= 4'h0;
        end else if (!ext_mode) begin
            // idle so a later mode switch starts clean
            tx_en_q <= 1'b0;
            txd_q <= 4'h0;
        end else if (txc_rise) begin
            // stands until the next edge
            // synchronised to phy transmit clock
            tx_en_q <= MII_TX_EN_IN;
            txd_q <= MII_TXD_IN;
        end
    end

    // ****************************************************************
    // link indicator
    // ****************************************************************
    // dedicated pin, never shared
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            // dark in reset
            LINK_INDICATOR_OUT <= 1'b0;
        end else begin
            LINK_INDICATOR_OUT <= LINK_UP_IN;
        end
    end

    // ****************************************************************
    // shared pins
    // ****************************************************************
    // one registered mux per pin keeps outputs glitch free
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            TX_ACTIVITY_INDICATOR_N_OUT <= 1'b1;
            RX_ACTIVITY_INDICATOR_N_OUT <= 1'b1;
            COLLISION_INDICATOR_N_OUT <= 1'b1;
            DUPLEX_INDICATOR_N_OUT <= 1'b1;
            SPEED_INDICATOR_N_OUT <= 1'b1;
        end else if (ext_mode) begin
            // pins turn high-active
            // enable plus nibble, msb first pin
            TX_ACTIVITY_INDICATOR_N_OUT <= tx_en_q;
            RX_ACTIVITY_INDICATOR_N_OUT <= txd_q[3];
            COLLISION_INDICATOR_N_OUT <= txd_q[2];
            DUPLEX_INDICATOR_N_OUT <= txd_q[1];
            SPEED_INDICATOR_N_OUT <= txd_q[0];
        end else if (indicator_mode && LINK_UP_IN) begin
            TX_ACTIVITY_INDICATOR_N_OUT <= !TX_ACTIVE_IN;

            RX_ACTIVITY_INDICATOR_N_OUT <= !RX_ACTIVE_IN;

            COLLISION_INDICATOR_N_OUT <= !(COLLISION_IN && !full_duplex);

            DUPLEX_INDICATOR_N_OUT <= !full_duplex;

            SPEED_INDICATOR_N_OUT <= !speed100;
        end else begin
            // no link or other mode: dark
            // dark pins draw no current
            TX_ACTIVITY_INDICATOR_N_OUT <= 1'b1;
            RX_ACTIVITY_INDICATOR_N_OUT <= 1'b1;
            COLLISION_INDICATOR_N_OUT <= 1'b1;
            DUPLEX_INDICATOR_N_OUT <= 1'b1;
            SPEED_INDICATOR_N_OUT <= 1'b1;
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    // setup and completion strobes
    assign apb_setup = PSEL_IN && !PENABLE_IN;

    // completes where ready is seen
    assign apb_done = PSEL_IN && PENABLE_IN && PREADY_OUT;

    // spare words answer an error
    assign addr_hit = is_mapped(PADDR_IN);

    // read data mux; unmapped reads as zero
    always_comb begin
        next_prdata = 32'h0000_0000;

        if (PADDR_IN == nipm_pkg::OFS_CONTROL) begin
            // setting field only
            next_prdata[nipm_pkg::CTL_OPSET_LSB +: 3] = phy_operation_setting;
        end else if (PADDR_IN == nipm_pkg::OFS_STATUS) begin
            // live levels, none latched
            next_prdata[nipm_pkg::STA_LINK] = LINK_UP_IN;
            next_prdata[nipm_pkg::STA_FULL_DUPLEX] = full_duplex;
            next_prdata[nipm_pkg::STA_SPEED100] = speed100;
            // clock source, pin mode and select code
            next_prdata[nipm_pkg::STA_PLL_LOCKED] = PLL_LOCKED_OUT;
            next_prdata[nipm_pkg::STA_CRYSTAL_SEL] = CRYSTAL_SELECT_OUT;
            next_prdata[nipm_pkg::STA_OSC_SEL] = OSC_SELECT_OUT;
            next_prdata[nipm_pkg::STA_INDICATOR_MODE] = indicator_mode;
            next_prdata[nipm_pkg::STA_EXT_MODE] = ext_mode;
            next_prdata[nipm_pkg::STA_CFG_LSB +: 4] = CFG_SELECT_IN;
        end else if (PADDR_IN == nipm_pkg::OFS_CLOCK) begin
            // fixed figures
            next_prdata[nipm_pkg::CLK_REF_LSB +: 8] = nipm_pkg::REF_CLOCK_MHZ;
            next_prdata[nipm_pkg::CLK_CORE_LSB +: 8] = nipm_pkg::CORE_CLOCK_MHZ;
            next_prdata[nipm_pkg::CLK_MULT_LSB +: 8] = nipm_pkg::PLL_MULTIPLIER;
        end
    end

    // ready in the first access cycle; data captured at setup
    // no wait state, with fully registered bus outputs
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else if (apb_setup) begin
            // answer in first access cycle
            PREADY_OUT <= 1'b1;
            PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : next_prdata;
            PSLVERR_OUT <= !addr_hit;
        end else begin
            // one-cycle pulse
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end
    end

    // control register write at completion only
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            // auto: negotiation rules
            phy_operation_setting <= nipm_pkg::CTL_OPSET_RESET;
        end else if (apb_done && PWRITE_IN && (PADDR_IN == nipm_pkg::OFS_CONTROL)) begin
            // manual duplex and speed setting
            // upper bits dropped
            phy_operation_setting <= PWDATA_IN[nipm_pkg::CTL_OPSET_LSB +: 3];
        end
    end

endmodule

// ===== bench/nipm_far_side.sv
/*
 * far side model: the external phy that feeds the transmit clock.
 * assumes the bench starts it only while an external phy mode is chosen.
 */
`timescale 1ns/1ps
module nipm_far_side (
    // clock
    input wire logic clk,
    // enable from the bench
    input wire logic run,
    // transmit clock towards the block
    output logic txc
);
    logic [1:0] div; // quarter-rate divider
    // clock stands low while stopped, so no false rising edge appears
    always_ff @(posedge clk) begin
        div <= run ? div + 2'h1 : 2'h0;
        txc <= run & div[1];
    end
endmodule

// ===== bench/nipm_assertions.sv
/*
 * concurrent checks on the pins of nipm_top.
 * assumes it is bound to nipm_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module nipm_assertions (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // watched inputs, grouped to keep the file short
    input wire logic [3:0] CFG_SELECT_IN,
    input wire logic LINK_UP_IN, TX_ACTIVE_IN, RX_ACTIVE_IN, COLLISION_IN,
    input wire logic MII_TXC_IN, MII_TX_EN_IN, PSEL_IN, PENABLE_IN,
    input wire logic [3:0] MII_TXD_IN,
    // watched outputs
    input wire logic PREADY_OUT, PSLVERR_OUT, LINK_INDICATOR_OUT,
    input wire logic TX_ACTIVITY_INDICATOR_N_OUT, RX_ACTIVITY_INDICATOR_N_OUT,
    input wire logic COLLISION_INDICATOR_N_OUT, DUPLEX_INDICATOR_N_OUT,
    input wire logic SPEED_INDICATOR_N_OUT, CRYSTAL_SELECT_OUT, OSC_SELECT_OUT,
    input wire logic PLL_LOCKED_OUT
);
    logic [4:0] pins; // the five shared pins, transmit first
    logic [3:0] cfg_prev; // select seen at the last edge
    logic [11:0] stable_cnt; // edges with an unchanged valid source
    logic warm; // unset (unknown) only before the first edge
    assign pins = {TX_ACTIVITY_INDICATOR_N_OUT, RX_ACTIVITY_INDICATOR_N_OUT,
        COLLISION_INDICATOR_N_OUT, DUPLEX_INDICATOR_N_OUT, SPEED_INDICATOR_N_OUT};
    // remember the select and mark the first edge as passed
    always_ff @(posedge CLK_IN) begin
        cfg_prev <= CFG_SELECT_IN;
        warm <= 1'b1;
    end
    // lock wait counter; saturates so a long run never wraps
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN || (CFG_SELECT_IN <= 4'h1) != (cfg_prev <= 4'h1) ||
            CFG_SELECT_IN > 4'h2 || cfg_prev > 4'h2) begin
            stable_cnt <= 12'h000;
        end else if (stable_cnt != 12'hFFF) begin
            stable_cnt <= stable_cnt + 12'h001;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    link_follow_a: assert property (
        $past(RESETN_IN) |-> LINK_INDICATOR_OUT == $past(LINK_UP_IN)) else $error("link pin wrong");
    tx_active_a: assert property ($past(RESETN_IN && CFG_SELECT_IN == 4'h0 && LINK_UP_IN)
        |-> TX_ACTIVITY_INDICATOR_N_OUT == !$past(TX_ACTIVE_IN)) else $error("tx pin wrong");
    rx_active_a: assert property ($past(RESETN_IN && CFG_SELECT_IN == 4'h0 && LINK_UP_IN)
        |-> RX_ACTIVITY_INDICATOR_N_OUT == !$past(RX_ACTIVE_IN)) else $error("rx pin wrong");
    coll_half_a: assert property ($past(RESETN_IN && CFG_SELECT_IN == 4'h0 && LINK_UP_IN)
        |-> COLLISION_INDICATOR_N_OUT == !($past(COLLISION_IN) && DUPLEX_INDICATOR_N_OUT))
        else $error("collision pin wrong");
    idle_nolink_a: assert property ($past(RESETN_IN && CFG_SELECT_IN == 4'h0 && !LINK_UP_IN)
        |-> pins == 5'h1F) else $error("pins not idle without link");
    reset_idle_a: assert property (disable iff (1'b0) warm && !$past(RESETN_IN)
        |-> pins == 5'h1F && !LINK_INDICATOR_OUT && !PREADY_OUT) else $error("reset state wrong");
    other_cfg_a: assert property ($past(RESETN_IN && CFG_SELECT_IN > 4'h2)
        |-> pins == 5'h1F) else $error("pins not idle in unused mode");
    ext_nibble_a: assert property ($past(RESETN_IN) && $rose(MII_TXC_IN) &&
        CFG_SELECT_IN inside {4'h1, 4'h2} ##1 $stable(CFG_SELECT_IN)
        |=> pins == {$past(MII_TX_EN_IN, 2), $past(MII_TXD_IN, 2)}) else $error("nibble wrong");
    src_select_a: assert property ($past(RESETN_IN) |->
        CRYSTAL_SELECT_OUT == ($past(CFG_SELECT_IN) <= 4'h1)
        && OSC_SELECT_OUT == ($past(CFG_SELECT_IN) == 4'h2)) else $error("clock source wrong");
    pll_lock_a: assert property (stable_cnt > 12'd1005 |-> PLL_LOCKED_OUT)
        else $error("lock missing after settle time");
    pll_early_a: assert property ($rose(PLL_LOCKED_OUT) |-> stable_cnt > 12'd995)
        else $error("lock too early");
    apb_ready_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT && !$past(PSLVERR_OUT))
        else $error("ready not in first access cycle");
endmodule
bind nipm_top nipm_assertions i_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .CFG_SELECT_IN(CFG_SELECT_IN), .LINK_UP_IN(LINK_UP_IN), .TX_ACTIVE_IN(TX_ACTIVE_IN),
    .RX_ACTIVE_IN(RX_ACTIVE_IN), .COLLISION_IN(COLLISION_IN), .MII_TXC_IN(MII_TXC_IN),
    .MII_TX_EN_IN(MII_TX_EN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .MII_TXD_IN(MII_TXD_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .LINK_INDICATOR_OUT(LINK_INDICATOR_OUT),
    .TX_ACTIVITY_INDICATOR_N_OUT(TX_ACTIVITY_INDICATOR_N_OUT),
    .RX_ACTIVITY_INDICATOR_N_OUT(RX_ACTIVITY_INDICATOR_N_OUT),
    .COLLISION_INDICATOR_N_OUT(COLLISION_INDICATOR_N_OUT),
    .DUPLEX_INDICATOR_N_OUT(DUPLEX_INDICATOR_N_OUT),
    .SPEED_INDICATOR_N_OUT(SPEED_INDICATOR_N_OUT), .CRYSTAL_SELECT_OUT(CRYSTAL_SELECT_OUT),
    .OSC_SELECT_OUT(OSC_SELECT_OUT), .PLL_LOCKED_OUT(PLL_LOCKED_OUT));

// ===== bench/tb.sv
/*
 * self-checking bench for nipm_top: registers over apb, indicator pins,
 * shared transmit pins and clock source selection.
 * assumes nipm_far_side supplies the external transmit clock.
 */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rstn = 1'b0, run = 1'b0, txc; // clock, reset, far side
    logic link = 1'b0, txa = 1'b0, rxa = 1'b0, col = 1'b0, afd = 1'b0, a100 = 1'b0;
    logic txen = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, perr, err;
    logic link_o, cry, osc, lock; // status pins
    logic [3:0] cfg = 4'h0, txd = 4'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    wire [4:0] pins; // transmit, receive, collision, duplex, speed
    int error_cnt = 0, checks = 0;
    always #50 clk = ~clk;
    nipm_far_side i_phy (.clk(clk), .run(run), .txc(txc));
    nipm_top i_dut (.CLK_IN(clk), .RESETN_IN(rstn), .CFG_SELECT_IN(cfg), .LINK_UP_IN(link),
        .TX_ACTIVE_IN(txa), .RX_ACTIVE_IN(rxa), .COLLISION_IN(col),
        .ANEG_FULL_DUPLEX_IN(afd), .ANEG_SPEED100_IN(a100), .MII_TXC_IN(txc),
        .MII_TX_EN_IN(txen), .MII_TXD_IN(txd), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(perr), .LINK_INDICATOR_OUT(link_o),
        .TX_ACTIVITY_INDICATOR_N_OUT(pins[4]), .RX_ACTIVITY_INDICATOR_N_OUT(pins[3]),
        .COLLISION_INDICATOR_N_OUT(pins[2]), .DUPLEX_INDICATOR_N_OUT(pins[1]),
        .SPEED_INDICATOR_N_OUT(pins[0]), .CRYSTAL_SELECT_OUT(cry), .OSC_SELECT_OUT(osc),
        .PLL_LOCKED_OUT(lock));
    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // register map: figures, read-only words, unmapped place, control
    task automatic t_regs();
        apb(1'b1, nipm_pkg::OFS_CLOCK, 32'hFFFFFFFF);
        chk("clock write err", 32'h0, 32'(err));
        apb(1'b0, nipm_pkg::OFS_CLOCK, 32'h0);
        chk("clock figures", 32'h00069619, rd);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b0, nipm_pkg::OFS_CONTROL, 32'h0);
        chk("control reset", 32'h0, rd);
        apb(1'b1, nipm_pkg::OFS_CONTROL, 32'hFFFFFFFC);
        apb(1'b0, nipm_pkg::OFS_CONTROL, 32'h0);
        chk("control field", 32'h4, rd);
        $display("test regs done");
    endtask
    // activity pins in internal phy mode
    task automatic t_act();
        txa <= 1'b1;
        rxa <= 1'b1;
        repeat (3) @(posedge clk);
        chk("no link pins", 32'h1F, 32'(pins));
        link <= 1'b1;
        rxa <= 1'b0;
        repeat (3) @(posedge clk);
        chk("link pin", 32'h1, 32'(link_o));
        chk("tx on rx off", 32'h1, 32'(pins[4:3]));
        apb(1'b0, nipm_pkg::OFS_STATUS, 32'h0);
        chk("status word", 32'h57, rd);
        txa <= 1'b0;
        rxa <= 1'b1;
        repeat (3) @(posedge clk);
        chk("tx off rx on", 32'h2, 32'(pins[4:3]));
        $display("test activity done");
    endtask
    // every operation setting, with collisions present throughout
    task automatic t_modes();
        logic half, ten;
        col <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            afd <= i[0];
            a100 <= i[2];
            apb(1'b1, nipm_pkg::OFS_CONTROL, 32'(i));
            repeat (3) @(posedge clk);
            half = (i == 1 || i == 3) || (i != 2 && i != 4 && !i[0]);
            ten = (i == 1 || i == 2) || (i != 3 && i != 4 && !i[2]);
            chk("col dup spd", 32'({!half, half, ten}), 32'(pins[2:0]));
        end
        $display("test modes done");
    endtask
    // shared pins in external modes, source selection and lock wait
    task automatic t_ext();
        cfg <= nipm_pkg::CFG_EXT_CRYSTAL;
        run <= 1'b1;
        txen <= 1'b1;
        txd <= 4'hA;
        repeat (12) @(posedge clk);
        chk("nibble a", 32'h1A, 32'(pins));
        chk("crystal src", 32'h2, 32'({cry, osc}));
        txen <= 1'b0;
        txd <= 4'h5;
        cfg <= nipm_pkg::CFG_EXT_OSC;
        repeat (12) @(posedge clk);
        chk("nibble 5", 32'h05, 32'(pins));
        chk("osc src", 32'h2, 32'({cry, osc, lock}));
        repeat (1010) @(posedge clk);
        chk("locked", 32'h1, 32'(lock));
        cfg <= 4'h3;
        repeat (3) @(posedge clk);
        chk("unused mode", 32'h1F, 32'({cry, osc, lock, pins}));
        run <= 1'b0;
        $display("test external done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clk);
        chk("reset pins", 32'h1F, 32'({link_o, pins}));
        rstn <= 1'b1;
        t_regs();
        t_act();
        t_modes();
        t_ext();
        wrap_up();
    end
endmodule
